/* File: logic/sfr_sequencer.sv */
// Power-on and hardware reset sequencer of a serial flash device.
// Operation
// RULE1: Run power-on initialisation for the whole power-up wait after supply good.
// RULE2: Host keeps select high and sends nothing during power-up wait.
// RULE3: Ignore the reset pin while power-on initialisation runs.
// RULE4: Reset low at end of power-up keeps device in reset until released.
// RULE5: Host waits release-to-select delay after reset rises before selecting.
// RULE6: Host holds reset high 50 ns before a new reset pulse.
// RULE7: Reset falling edge restores registers with a 35 us shortened process.
// RULE8: If power-on failed, reset falling edge reruns the full power-up process.
// RULE9: Reset pulse of 200 ns or more aborts any operation in progress.
// RULE10: During busy window float outputs, reject commands, then return to standby.
// RULE11: Host raises select during busy window if it was low at reset.
// RULE12: Host keeps select high until 35 us after reset falls.
// RULE13: Host keeps reset high 50 ns before selecting after a reset.
// RULE14: Host makes pulse width plus release delay cover the busy window.
// RULE15: Host limits serial clock to 50 MHz plain reads, 133 MHz others.
// RULE16: Host limits serial clock to 104 MHz for dual and quad reads.
// RULE17: Host limits serial clock to 80 MHz for quad page program.
// RULE18: Select high with no operation pending puts the device in standby.
// RULE19: Host counts minimum intervals in its own cycles, rounding up.
// RULE20: Host tracks reset phases with an explicit state machine.
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_sequencer
  import sfr_pkg::*;
#(
  parameter int POWER_UP_CYC = `SFR_POWER_UP_CYC,
  parameter int BUSY_CYC = `SFR_BUSY_CYC,
  parameter int PULSE_CYC = `SFR_PULSE_CYC,
  parameter int CNT_W = 20
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Supply monitor level, high once the core supply is above threshold.
  input wire logic supply_good,
  // Pins from the host.
  input wire logic reset_pin_n,
  input wire logic select_n,
  // Core status and control.
  input wire logic op_pending,
  input wire logic por_fault,
  output logic abort_op,
  output logic regs_restore,
  output logic outputs_float,
  output logic cmd_accept,
  output logic standby,
  output logic init_busy,
  output logic por_done
);
  sfr_state_t state_r;
  sfr_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] pulse_cnt_r;
  logic supply_s;
  logic rst_pin_s;
  logic sel_s;
  logic rst_pin_d_r;
  logic por_ok_r;
  logic fall;
  logic [CNT_W-1:0] por_lim;
  logic [CNT_W-1:0] busy_lim;

  // Elaboration checks refuse counts that the interval counters cannot serve.
  if (POWER_UP_CYC < 1 || BUSY_CYC < 1 || PULSE_CYC < 1)
  begin : g_count_low
    $error("sfr_sequencer: counts must be at least one");
  end
  if (CNT_W < 2 || CNT_W > 30 || POWER_UP_CYC >= (1 << CNT_W) || BUSY_CYC >= (1 << CNT_W)
      || PULSE_CYC >= (1 << CNT_W))
  begin : g_count_wide
    $error("sfr_sequencer: counter width cannot hold the counts");
  end

  // Pin and supply inputs are resynchronised before use.
  sfr_sync #(.WIDTH(3), .INIT(3'h6)) i_sfr_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({reset_pin_n, select_n, supply_good}),
    .sync_out({rst_pin_s, sel_s, supply_s})
  );

  assign por_lim = CNT_W'(POWER_UP_CYC - 1);
  assign busy_lim = CNT_W'(BUSY_CYC - 1);
  assign fall = rst_pin_d_r && !rst_pin_s;

  // Previous reset pin level for falling edge detection.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_pin_d_r <= 1'b1;
    else
      rst_pin_d_r <= rst_pin_s;
  end

  // Next state of the reset sequence.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SFR_POR:
      begin
        if (!supply_s)
          state_nxt = SFR_POR;
        else if (cnt_r == por_lim)
          state_nxt = rst_pin_s ? SFR_READY : SFR_HELD; // [RULE1] [RULE3] [RULE4]
      end
      SFR_HELD:
        if (rst_pin_s)
          state_nxt = SFR_READY; // [RULE4]
      SFR_READY:
        if (fall)
          state_nxt = por_ok_r ? SFR_PULSE : SFR_POR; // [RULE7] [RULE8]
      SFR_PULSE:
        if (cnt_r == busy_lim)
          state_nxt = SFR_BUSY;
      SFR_BUSY:
        if (rst_pin_s)
          state_nxt = SFR_READY; // [RULE10]
      default:
        state_nxt = SFR_POR;
    endcase
  end

  // State register; loss of supply restarts power-on initialisation.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= SFR_POR;
    else if (!supply_s)
      state_r <= SFR_POR;
    else
      state_r <= state_nxt;
  end

  // Interval counter, restarted on every state change.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= '0;
    else if (!supply_s || state_nxt != state_r)
      cnt_r <= '0;
    else if (cnt_r != {CNT_W{1'b1}})
      cnt_r <= cnt_r + 1'b1;
  end

  // Low-time counter of the reset pin for minimum pulse qualification.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      pulse_cnt_r <= '0;
    else if (rst_pin_s)
      pulse_cnt_r <= '0;
    else if (pulse_cnt_r != {CNT_W{1'b1}})
      pulse_cnt_r <= pulse_cnt_r + 1'b1;
  end

  // Abort strobe once a reset pulse reaches the minimum width.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      abort_op <= 1'b0;
    else
      abort_op <= !rst_pin_s && pulse_cnt_r == CNT_W'(PULSE_CYC - 1)
                  && state_r != SFR_POR; // [RULE9]
  end

  // Power-on success flag, recorded when power-up ends and lost together with the supply.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      por_ok_r <= 1'b0;
    else if (!supply_s)
      por_ok_r <= 1'b0;
    else if (state_r == SFR_POR && state_nxt != SFR_POR)
      por_ok_r <= !por_fault; // [RULE8]
  end

  // Status outputs registered from the next state; the restore strobe reads the current state instead, and power-on done reads both.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regs_restore <= 1'b0;
      outputs_float <= 1'b1;
      cmd_accept <= 1'b0;
      standby <= 1'b0;
      init_busy <= 1'b1;
      por_done <= 1'b0;
    end
    else
    begin
      regs_restore <= state_r == SFR_READY && fall && por_ok_r; // [RULE7] [RULE8]
      outputs_float <= state_nxt != SFR_READY; // [RULE10]
      cmd_accept <= state_nxt == SFR_READY && !sel_s;
      standby <= state_nxt == SFR_READY && sel_s && !op_pending; // [RULE18]
      init_busy <= state_nxt == SFR_POR || state_nxt == SFR_PULSE;
      por_done <= supply_s && (por_ok_r || (state_r == SFR_POR && state_nxt != SFR_POR));
    end
  end
endmodule

/* File: shared/sfr_defs.svh */
// Timing constants for the flash reset sequencer.
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
`define SFR_CLK_MHZ 250
`define SFR_POWER_UP_WAIT_US 300
`define SFR_RESET_BUSY_WINDOW_US 35
`define SFR_RESET_PULSE_MIN_NS 200
`define SFR_RESET_HIGH_RECOVERY_NS 50
`define SFR_RELEASE_TO_SELECT_DELAY_NS 50
`define SFR_POWER_UP_CYC (`SFR_POWER_UP_WAIT_US * `SFR_CLK_MHZ)
`define SFR_BUSY_CYC (`SFR_RESET_BUSY_WINDOW_US * `SFR_CLK_MHZ)
`define SFR_PULSE_CYC ((`SFR_RESET_PULSE_MIN_NS * `SFR_CLK_MHZ + 999) / 1000)
`define SFR_RECOVERY_CYC ((`SFR_RESET_HIGH_RECOVERY_NS * `SFR_CLK_MHZ + 999) / 1000)
`endif

/* File: shared/sfr_pkg.sv */
// Types shared by the flash reset sequencer.
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_POR = 3'h0,
    SFR_HELD = 3'h1,
    SFR_READY = 3'h2,
    SFR_PULSE = 3'h3,
    SFR_BUSY = 3'h4
  } sfr_state_t;
endpackage

/* File: logic/sfr_sync.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module sfr_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Asynchronous input and synchronised output.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // Only the second stage reads the first.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* File: tb/sfr_sequencer_assertions.sv */
// Port checker for the flash reset sequencer.
`timescale 1ns/1ps
module sfr_sequencer_assertions (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Inputs.
  input wire logic supply_good,
  input wire logic reset_pin_n,
  input wire logic select_n,
  input wire logic op_pending,
  input wire logic por_fault,
  // Outputs.
  input wire logic abort_op,
  input wire logic regs_restore,
  input wire logic outputs_float,
  input wire logic cmd_accept,
  input wire logic standby,
  input wire logic init_busy,
  input wire logic por_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_acc; cmd_accept |-> !outputs_float && !init_busy; endproperty
  a_acc: assert property (p_acc) else $error("accept while busy");
  property p_sel; select_n [*4] |-> !cmd_accept; endproperty
  a_sel: assert property (p_sel) else $error("accept while deselected");
  property p_sb; standby |-> !$past(op_pending) && !cmd_accept; endproperty
  a_sb: assert property (p_sb) else $error("standby while active");
  property p_rst; regs_restore |=> init_busy [*8]; endproperty
  a_rst: assert property (p_rst) else $error("restore without busy");
  property p_abt; abort_op |-> !$past(reset_pin_n, 8); endproperty
  a_abt: assert property (p_abt) else $error("abort on short pulse");
  property p_por; !por_done |-> !regs_restore; endproperty
  a_por: assert property (p_por) else $error("restore before power-up done");
  property p_sup; !supply_good [*5] |-> !por_done; endproperty
  a_sup: assert property (p_sup) else $error("done without supply");
  property p_hld; $fell(reset_pin_n) ##1 !reset_pin_n [*6] |-> outputs_float; endproperty
  a_hld: assert property (p_hld) else $error("drives while pin low");
endmodule
bind sfr_sequencer sfr_sequencer_assertions i_chk (.core_clk, .reset_n, .supply_good,
  .reset_pin_n, .select_n, .op_pending, .por_fault, .abort_op, .regs_restore,
  .outputs_float, .cmd_accept, .standby, .init_busy, .por_done);

/* File: tb/sfr_host_model.sv */
// Host model pulsing the reset pin, gating chip select and clocking the link.
`timescale 1ns/1ps
module sfr_host_model #(
  parameter int HOLD = 53,
  parameter int PWR = 60,
  parameter int SCK_HALF = 10
) (
  // Clock and requests.
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] low_cyc,
  input wire logic sel_req,
  // Pins.
  output logic reset_pin_n,
  output logic select_n,
  output logic sck
);
  // Host reset phases, run from time zero: ready, reset low, and one hold covering busy and release.
  typedef enum logic [1:0] {
    SFR_HM_IDLE = 2'h0,
    SFR_HM_LOW = 2'h1,
    SFR_HM_HOLD = 2'h2
  } sfr_hm_state_t;
  sfr_hm_state_t st = SFR_HM_IDLE;
  int lo = 0;
  int hold = 0;
  int pwr = PWR;
  int sck_cnt = 0;

  // Half periods of 4 ns core cycles; three or more keep the link at or below 50 MHz.
  if (SCK_HALF < 3)
  begin : g_sck_fast
    $error("sfr_host_model: serial clock above the slowest command ceiling");
  end

  // Select waits out power-up, pulse, busy window and release delay, counted rounded up.
  assign select_n = !(sel_req && st == SFR_HM_IDLE && pwr == 0);
  assign reset_pin_n = st != SFR_HM_LOW;

  // Power-up wait before the first selection.
  always @(posedge core_clk)
  begin
    if (pwr > 0)
      pwr <= pwr - 1;
  end

  // A new pulse starts only from ready, so the recovery gap always precedes it.
  always @(posedge core_clk)
  begin
    case (st)
      SFR_HM_IDLE:
        if (go)
        begin
          lo <= low_cyc;
          st <= SFR_HM_LOW;
        end
      SFR_HM_LOW:
        if (lo > 1)
          lo <= lo - 1;
        else
        begin
          hold <= HOLD;
          st <= SFR_HM_HOLD;
        end
      SFR_HM_HOLD:
        if (hold > 1)
          hold <= hold - 1;
        else
          st <= SFR_HM_IDLE;
      default:
        st <= SFR_HM_IDLE;
    endcase
  end

  // The serial clock runs only inside a selection and stands low outside it.
  always @(posedge core_clk)
  begin
    if (select_n)
    begin
      sck <= 1'b0;
      sck_cnt <= 0;
    end
    else if (sck_cnt == SCK_HALF - 1)
    begin
      sck <= ~sck;
      sck_cnt <= 0;
    end
    else
      sck_cnt <= sck_cnt + 1;
  end
endmodule

/* File: tb/sfr_sequencer_tb.sv */
// Self-checking bench for the flash reset sequencer.
`timescale 1ns/1ps
module sfr_sequencer_tb;
  logic core_clk = 0, reset_n = 0, supply_good = 0, op_pending = 0, por_fault = 0;
  logic go = 0, sel_req = 0, abort_op, regs_restore, outputs_float, cmd_accept;
  logic standby, init_busy, por_done, reset_pin_n, select_n, sck;
  logic [7:0] low_cyc = 8'h00;
  logic [7:0] wid [2] = '{8'h3C, 8'h0A};
  int n_fail = 0, n_checks = 0, seed = 93199, ticks = 0, n_ab = 0, n_rs = 0, a0, r0;
  sfr_sequencer #(.POWER_UP_CYC(50), .BUSY_CYC(40)) i_sfr_sequencer (.core_clk, .reset_n,
    .supply_good, .reset_pin_n, .select_n, .op_pending, .por_fault, .abort_op, .regs_restore,
    .outputs_float, .cmd_accept, .standby, .init_busy, .por_done);
  sfr_host_model #(.HOLD(53)) i_sfr_host_model (.core_clk, .go, .low_cyc, .sel_req,
    .reset_pin_n, .select_n, .sck);
  always #2 core_clk = ~core_clk;
  // Counts pulses and cuts a hung run short.
  always @(posedge core_clk)
  begin
    ticks++;
    n_ab += abort_op;
    n_rs += regs_restore;
    if (ticks == 5000)
    begin
      n_fail++;
      close_out();
    end
  end
  task chk(input logic s, input logic e);
    n_checks++;
    if (s !== e)
      $display("FAIL %0t mismatch", $time);
    if (s !== e)
      n_fail++;
  endtask
  function logic exp_sb(input logic s, input logic o);
    return s & ~o;
  endfunction
  task pulse(input logic [7:0] w);
    @(posedge core_clk);
    go <= 1'b1;
    low_cyc <= w;
    @(negedge core_clk iff !reset_pin_n);
    @(posedge core_clk);
    go <= 1'b0;
  endtask
  task close_out();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Power-up with the pin low across its end, warm pulses, random select, faulty power-up.
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    supply_good <= 1'b1;
    pulse(8'hFF);
    repeat (30) @(negedge core_clk);
    chk(init_busy, 1'b1);
    repeat (40) @(negedge core_clk);
    chk(outputs_float, 1'b1);
    repeat (200) @(negedge core_clk);
    chk(outputs_float, 1'b0);
    chk(n_rs == 0, 1'b1);
    chk(por_done, 1'b1);
    foreach (wid[i])
    begin
      a0 = n_ab;
      r0 = n_rs;
      pulse(wid[i]);
      repeat (20) @(negedge core_clk);
      chk(outputs_float & ~cmd_accept, 1'b1);
      repeat (120) @(negedge core_clk);
      chk(n_rs - r0 == 1, 1'b1);
      chk(n_ab - a0 == (wid[i] >= 50), 1'b1);
      chk(init_busy, 1'b0);
    end
    repeat (20)
    begin
      @(posedge core_clk);
      sel_req <= 1'($random(seed));
      op_pending <= 1'($random(seed));
      repeat (6) @(negedge core_clk);
      chk(standby, exp_sb(select_n, op_pending));
      chk(cmd_accept, ~select_n);
      chk(sck & select_n, 1'b0);
    end
    @(posedge core_clk);
    sel_req <= 1'b0;
    por_fault <= 1'b1;
    supply_good <= 1'b0;
    repeat (10) @(posedge core_clk);
    supply_good <= 1'b1;
    repeat (80) @(posedge core_clk);
    r0 = n_rs;
    pulse(8'h0A);
    repeat (46) @(negedge core_clk);
    chk(init_busy, 1'b1);
    chk(n_rs == r0, 1'b1);
    chk(por_done, 1'b0);
    close_out();
  end
endmodule
